/* File: logic/enc_pkg.sv */
// Constants for the word encoder: sequencing points, divider, register map.
// Assumes a single system clock; all slower rates are enable pulses.
package enc_pkg;

  // ----------------------------------------------------------------
  // Word sequencing, counted in half-bit times
  // ----------------------------------------------------------------
  localparam logic [5:0] HALF_SYNC_SPLIT = 6'h03;
  localparam logic [5:0] HALF_SYNC_END   = 6'h06;
  localparam logic [5:0] HALF_DATA_END   = 6'h26;
  localparam logic [5:0] HALF_LAST       = 6'h27;
  localparam logic [5:0] HALF_REQ_ON     = 6'h05;
  localparam logic [5:0] HALF_REQ_OFF    = 6'h25;
  localparam logic [5:0] HALF_RESET      = 6'h00;
  localparam logic       PARITY_SEED     = 1'b1;

  // ----------------------------------------------------------------
  // Divide-by-six
  // ----------------------------------------------------------------
  localparam logic [2:0] DIV_LAST  = 3'h5;
  localparam logic [2:0] DIV_HALF  = 3'h3;
  localparam logic [2:0] DIV_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_STATUS    = 8'h04;
  localparam logic [7:0]  OFF_WORDS     = 8'h08;
  localparam int unsigned CTRL_DRIVE    = 0;
  localparam int unsigned CTRL_ABORT    = 1;
  localparam logic        CTRL_DRIVE_RV = 1'b1;
  localparam logic [15:0] WORDS_RESET   = 16'h0000;

  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_ARMED = 3'b010,
    ST_SEND  = 3'b100
  } enc_state_t;

endpackage : enc_pkg

/* File: logic/enc_ctl_if.sv */
// Control and status between the register slave and the encoder core.
// Assumes both ends run on the same clock.
interface enc_ctl_if;
  logic        drive_en;
  logic        abort;
  logic        busy;
  logic        data_req;
  logic        cmd_sync;
  logic [15:0] words;

  modport regs (output drive_en, output abort,
                input busy, input data_req, input cmd_sync, input words);
  modport core (input drive_en, input abort,
                output busy, output data_req, output cmd_sync, output words);
endinterface : enc_ctl_if

/* File: logic/div6_counter.sv */
// Divide-by-six of the system clock into a square wave output.
// Assumes clr is synchronous to clk.
module div6_counter
  import enc_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clr,
  output logic      div_out
);

  logic [2:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q   <= DIV_RESET;
      div_out <= 1'b0;
    end
    else if (clr)
    begin
      cnt_q   <= DIV_RESET;
      div_out <= 1'b0;
    end
    else
    begin
      cnt_q   <= (cnt_q == DIV_LAST) ? DIV_RESET : cnt_q + 3'h1;
      div_out <= cnt_q < DIV_HALF;
    end
  end

endmodule : div6_counter

/* File: logic/enc_ahb_regs.sv */
// AHB-Lite slave holding the encoder control, status and word count.
// Assumes single word transfers; never inserts wait states, always OKAY.
module enc_ahb_regs
  import enc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  enc_ctl_if.regs          ctl
);

  logic       wr_pend_q;
  logic [7:0] wr_addr_q;
  logic       drive_q;
  logic       abort_q;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  wire        take       = hsel & htrans[1] & hready;
  wire        ctrl_wr    = wr_pend_q & (wr_addr_q == OFF_CTRL);
  wire        drive_next = ctrl_wr ? hwdata[CTRL_DRIVE] : drive_q;
  wire [31:0] rd_val     =
      (haddr[7:0] == OFF_CTRL)   ? {31'h0, drive_next} :
      (haddr[7:0] == OFF_STATUS) ? {29'h0, ctl.cmd_sync, ctl.data_req, ctl.busy} :
      (haddr[7:0] == OFF_WORDS)  ? {16'h0, ctl.words} : 32'h0;

  assign ctl.drive_en = drive_q;
  assign ctl.abort    = abort_q;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h00;
      drive_q   <= CTRL_DRIVE_RV;
      abort_q   <= 1'b0;
      hrdata    <= 32'h0;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend_q <= take & hwrite;
      wr_addr_q <= take ? haddr[7:0] : wr_addr_q;
      drive_q   <= drive_next;
      abort_q   <= ctrl_wr & hwdata[CTRL_ABORT];
      if (take && !hwrite)
      begin
        hrdata <= rd_val;
      end
    end
  end

endmodule : enc_ahb_regs

/* File: logic/manchester_word_encoder.sv */
// Manchester II word encoder: sync, sixteen data bits and parity on a
// bipolar pair of active-low line outputs, with a serial data handshake.
// Assumes all pins are synchronous to CLK (the encoder clock).
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
module manchester_word_encoder
  import enc_pkg::*;
(
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        MRST,
  input  wire logic        SEND_CLK_IN,
  input  wire logic        TX_ENABLE,
  input  wire logic        SYNC_SEL,
  input  wire logic        TX_SERIAL_INPUT,
  input  wire logic        INHIBIT_N,
  output logic             SHIFT_CLK,
  output logic             SEND_DATA,
  output logic             DIV6_OUT,
  output logic             LINE_POS_N,
  output logic             LINE_NEG_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP
);

  import enc_pkg::*;

  // ----------------------------------------------------------------
  // Registers and control carrier
  // ----------------------------------------------------------------
  enc_ctl_if ctl ();

  enc_ahb_regs u_regs
  (
    .clk       (CLK),
    .rst_n     (RST_N),
    .hsel      (HSEL),
    .haddr     (HADDR),
    .htrans    (HTRANS),
    .hwrite    (HWRITE),
    .hwdata    (HWDATA),
    .hready    (HREADY),
    .hrdata    (HRDATA),
    .hreadyout (HREADYOUT),
    .hresp     (HRESP),
    .ctl       (ctl.regs)
  );

  // ----------------------------------------------------------------
  // Divide-by-six output
  // ----------------------------------------------------------------
  div6_counter u_div6
  (
    .clk     (CLK),
    .rst_n   (RST_N),
    .clr     (MRST),
    .div_out (DIV6_OUT)
  );

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  enc_state_t  state_q;
  enc_state_t  state_d;
  logic [5:0]  half_q;
  logic [5:0]  half_d;
  logic        sck_prev_q;
  logic        shclk_q;
  logic        rst_pend_q;
  logic        again_q;
  logic        again_d;
  logic        cmd_q;
  logic        cmd_d;
  logic        cur_q;
  logic        cur_d;
  logic        par_q;
  logic        par_d;
  logic        req_q;
  logic        req_d;
  logic        pos_q;
  logic        pos_d;
  logic        neg_q;
  logic        neg_d;
  logic [15:0] words_q;
  logic [15:0] words_d;

  // ----------------------------------------------------------------
  // Clock events and decode
  // ----------------------------------------------------------------
  wire       send_tick  = SEND_CLK_IN & ~sck_prev_q;
  wire       tick_rise  = send_tick & ~shclk_q;
  wire       tick_fall  = send_tick & shclk_q;
  wire       reset_req  = MRST | ctl.abort;
  wire       enc_clear  = send_tick & (rst_pend_q | reset_req);
  wire [5:0] half_inc   = half_q + 6'h01;
  wire       in_sync    = half_inc < HALF_SYNC_END;
  wire       sync_first = half_inc < HALF_SYNC_SPLIT;
  wire       bit_half   = ~half_inc[0];
  wire       in_data    = half_inc < HALF_DATA_END;
  wire       bit_now    = in_data ? TX_SERIAL_INPUT : par_q;
  wire       sync_level = sync_first ? cmd_q : ~cmd_q;
  wire       data_level = bit_half ? bit_now : ~cur_q;
  wire       level_next = in_sync ? sync_level : data_level;
  wire       word_done  = half_q == HALF_LAST;
  wire       drive_ok   = INHIBIT_N & ctl.drive_en;

  assign SHIFT_CLK    = shclk_q;
  assign SEND_DATA    = req_q;
  assign ctl.busy     = state_q != ST_IDLE;
  assign ctl.data_req = req_q;
  assign ctl.cmd_sync = cmd_q;
  assign ctl.words    = words_q;

  // ----------------------------------------------------------------
  // Word sequencer
  // ----------------------------------------------------------------
  always_comb
  begin
    state_d = state_q;
    half_d  = half_q;
    again_d = again_q;
    cmd_d   = cmd_q;
    cur_d   = cur_q;
    par_d   = par_q;
    req_d   = req_q;
    pos_d   = pos_q;
    neg_d   = neg_q;
    words_d = words_q;
    if (enc_clear)
    begin
      state_d = ST_IDLE;
      half_d  = HALF_RESET;
      again_d = 1'b0;
      req_d   = 1'b0;
      pos_d   = 1'b0;
      neg_d   = 1'b0;
    end
    else if (send_tick)
    begin
      unique case (state_q)
        ST_IDLE:
        begin
          if (tick_fall && TX_ENABLE)
          begin
            state_d = ST_ARMED;
          end
        end
        ST_ARMED:
        begin
          state_d = ST_SEND;
          half_d  = HALF_RESET;
          cmd_d   = SYNC_SEL;
          par_d   = PARITY_SEED;
          pos_d   = SYNC_SEL;
          neg_d   = ~SYNC_SEL;
        end
        ST_SEND:
        begin
          if (word_done)
          begin
            words_d = words_q + 16'h0001;
            again_d = 1'b0;
            if (again_q)
            begin
              half_d = HALF_RESET;
              cmd_d  = SYNC_SEL;
              par_d  = PARITY_SEED;
              pos_d  = SYNC_SEL;
              neg_d  = ~SYNC_SEL;
            end
            else
            begin
              state_d = ST_IDLE;
              pos_d   = 1'b0;
              neg_d   = 1'b0;
            end
          end
          else
          begin
            half_d = half_inc;
            pos_d  = level_next;
            neg_d  = ~level_next;
            if (!in_sync && bit_half)
            begin
              cur_d = bit_now;
            end
            if (!in_sync && bit_half && in_data)
            begin
              par_d = par_q ^ TX_SERIAL_INPUT;
            end
            if (half_inc == HALF_REQ_ON)
            begin
              req_d = 1'b1;
            end
            if (half_inc == HALF_REQ_OFF)
            begin
              req_d = 1'b0;
            end
            if (half_inc == HALF_LAST)
            begin
              again_d = TX_ENABLE;
            end
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shift clock and pending abort
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      sck_prev_q <= 1'b0;
      shclk_q    <= 1'b0;
      rst_pend_q <= 1'b0;
    end
    else
    begin
      sck_prev_q <= SEND_CLK_IN;
      if (MRST)
      begin
        shclk_q <= 1'b0;
      end
      else if (send_tick)
      begin
        shclk_q <= ~shclk_q;
      end
      if (reset_req)
      begin
        rst_pend_q <= 1'b1;
      end
      else if (send_tick)
      begin
        rst_pend_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      state_q <= ST_IDLE;
      half_q  <= HALF_RESET;
      again_q <= 1'b0;
      cmd_q   <= 1'b0;
      cur_q   <= 1'b0;
      par_q   <= PARITY_SEED;
      req_q   <= 1'b0;
      pos_q   <= 1'b0;
      neg_q   <= 1'b0;
      words_q <= WORDS_RESET;
    end
    else
    begin
      state_q <= state_d;
      half_q  <= half_d;
      again_q <= again_d;
      cmd_q   <= cmd_d;
      cur_q   <= cur_d;
      par_q   <= par_d;
      req_q   <= req_d;
      pos_q   <= pos_d;
      neg_q   <= neg_d;
      words_q <= words_d;
    end
  end

  // ----------------------------------------------------------------
  // Line drive, gated every clock so inhibit acts on the next CLK edge
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      LINE_POS_N <= 1'b1;
      LINE_NEG_N <= 1'b1;
    end
    else
    begin
      LINE_POS_N <= ~(pos_d & drive_ok);
      LINE_NEG_N <= ~(neg_d & drive_ok);
    end
  end

endmodule : manchester_word_encoder

/* File: bench/enc_asserts.sv */
// Checker on the encoder top pins: line drive, divider, request window.
// Assumes SEND_CLK_IN is fed from DIV6_OUT, so one send tick per six CLK.
module enc_asserts
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic MRST,
  input wire logic INHIBIT_N,
  input wire logic SHIFT_CLK,
  input wire logic SEND_DATA,
  input wire logic DIV6_OUT,
  input wire logic LINE_POS_N,
  input wire logic LINE_NEG_N,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE
);
  logic [7:0] req_len_q;
  logic       cut_q;

  default clocking dck @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  // ----
  // Request length in CLK, waived after MRST or any bus write, until the request ends
  // ----
  always_ff @(posedge CLK or negedge RST_N)
    if (!RST_N)
    begin
      req_len_q <= 8'h00;
      cut_q     <= 1'b0;
    end
    else
    begin
      req_len_q <= SEND_DATA ? req_len_q + 8'h01 : 8'h00;
      cut_q     <= MRST || (HSEL && HTRANS[1] && HWRITE) || (SEND_DATA && cut_q);
    end

  // ----
  // Properties
  // ----
  a_lines_exclusive: assert property (!(!LINE_POS_N && !LINE_NEG_N))
    else $error("Both line outputs active");
  a_inhibit_idle: assert property (!INHIBIT_N && !$past(INHIBIT_N)
    |-> LINE_POS_N && LINE_NEG_N) else $error("Line driven while inhibited");
  a_div6_shape: assert property ($rose(DIV6_OUT)
    |-> (DIV6_OUT[*3] ##1 !DIV6_OUT[*3]) or (##[0:6] MRST)) else $error("Divider shape");
  a_mrst_holds: assert property (MRST && $past(MRST)
    |-> !DIV6_OUT && !SHIFT_CLK) else $error("Counters run in master reset");
  a_shift_half: assert property ($rose(SHIFT_CLK)
    |-> (SHIFT_CLK[*6] ##1 !SHIFT_CLK) or (##[0:6] MRST)) else $error("Shift clock shape");
  a_req_sixteen: assert property ($fell(SEND_DATA) && !cut_q
    |-> req_len_q == 8'hC0) else $error("Request window length");
  a_req_on_fall: assert property ($rose(SEND_DATA) |-> $fell(SHIFT_CLK))
    else $error("Request not on falling shift edge");
  a_abort_clears: assert property ($fell(MRST)
    |-> ##[1:12] (!SEND_DATA && LINE_POS_N && LINE_NEG_N)) else $error("Abort left word");
  a_bus_okay: assert property (!HRESP)
    else $error("Bus response not okay");
  a_zero_wait: assert property ($past(RST_N) |-> HREADYOUT)
    else $error("Bus wait state inserted");
endmodule : enc_asserts

bind manchester_word_encoder enc_asserts chk_u
(
  .CLK        (CLK),
  .RST_N      (RST_N),
  .MRST       (MRST),
  .INHIBIT_N  (INHIBIT_N),
  .SHIFT_CLK  (SHIFT_CLK),
  .SEND_DATA  (SEND_DATA),
  .DIV6_OUT   (DIV6_OUT),
  .LINE_POS_N (LINE_POS_N),
  .LINE_NEG_N (LINE_NEG_N),
  .HREADYOUT  (HREADYOUT),
  .HRESP      (HRESP),
  .HSEL       (HSEL),
  .HTRANS     (HTRANS),
  .HWRITE     (HWRITE)
);

/* File: bench/line_source_model.sv */
// Serial word source and line sampler at the encoder's far side.
// Assumes send ticks every six CLK; each half-bit is sampled mid-way.
module line_source_model
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        shift_clk,
  input  wire logic        send_data,
  input  wire logic        send_clk,
  input  wire logic        line_pos_n,
  input  wire logic        line_neg_n,
  input  wire logic [15:0] word,
  output logic             serial_out,
  output logic      [79:0] halves
);
  logic       shift_q;
  logic       send_clk_q;
  logic [3:0] bit_q;
  logic [2:0] mid_q;
  wire        shift_fell = shift_q && !shift_clk;
  wire        tick       = !send_clk_q && send_clk;

  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      shift_q    <= 1'b0;
      send_clk_q <= 1'b0;
      bit_q      <= 4'h0;
      mid_q      <= 3'h0;
      serial_out <= 1'b0;
      halves     <= '0;
    end
    else
    begin
      shift_q    <= shift_clk;
      send_clk_q <= send_clk;
      mid_q      <= tick ? 3'h0 : mid_q + 3'h1;
      if (mid_q == 3'h3)
        halves <= {halves[77:0], line_pos_n, line_neg_n};
      // Not requested: keep changing so no stale bit passes
      if (!send_data)
      begin
        bit_q      <= 4'h0;
        serial_out <= !serial_out;
      end
      else if (shift_fell)
      begin
        serial_out <= word[4'hF - bit_q];
        bit_q      <= bit_q + 4'h1;
      end
    end
endmodule : line_source_model

/* File: bench/manchester_word_encoder_bench.sv */
// Self-checking bench for the Manchester word encoder and its registers.
// Assumes the package map; the send clock comes from the divider output.
module manchester_word_encoder_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import enc_pkg::*;

  typedef struct packed
  {
    logic        cmd;
    logic [15:0] data;
    logic        par;
  } row_t;

  localparam row_t ROWS [4] = '{'{1'b1, 16'hA5C3, 1'b1}, '{1'b0, 16'h0001, 1'b0},
                                '{1'b1, 16'h7FFF, 1'b0}, '{1'b0, 16'h0000, 1'b1}};

  logic        clk, rst_n, mrst, tx_en, sync_sel, inhibit_n, hsel, hwrite;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic        shift_clk, send_data, div6_out, line_pos_n, line_neg_n, hreadyout, hresp, sdin;
  logic [15:0] word;
  logic [79:0] halves, got, exp_h;
  int          n_errors, checks_done, cyc, t0;

`define CHK(nm, ex, gt) \
  begin \
    checks_done++; \
    if ((gt) !== (ex)) \
    begin \
      n_errors++; \
      $display("[ERR] %s exp %h got %h", nm, ex, gt); \
    end \
  end

  manchester_word_encoder dut_u
  (
    .CLK             (clk),
    .RST_N           (rst_n),
    .MRST            (mrst),
    .SEND_CLK_IN     (div6_out),
    .TX_ENABLE       (tx_en),
    .SYNC_SEL        (sync_sel),
    .TX_SERIAL_INPUT (sdin),
    .INHIBIT_N       (inhibit_n),
    .SHIFT_CLK       (shift_clk),
    .SEND_DATA       (send_data),
    .DIV6_OUT        (div6_out),
    .LINE_POS_N      (line_pos_n),
    .LINE_NEG_N      (line_neg_n),
    .HSEL            (hsel),
    .HADDR           (haddr),
    .HTRANS          (htrans),
    .HWRITE          (hwrite),
    .HSIZE           (hsize),
    .HWDATA          (hwdata),
    .HREADY          (hreadyout),
    .HRDATA          (hrdata),
    .HREADYOUT       (hreadyout),
    .HRESP           (hresp)
  );

  line_source_model src_u
  (
    .clk        (clk),
    .rst_n      (rst_n),
    .shift_clk  (shift_clk),
    .send_data  (send_data),
    .send_clk   (div6_out),
    .line_pos_n (line_pos_n),
    .line_neg_n (line_neg_n),
    .word       (word),
    .serial_out (sdin),
    .halves     (halves)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk)
    cyc <= cyc + 1;

  // ----
  // Tasks
  // ----
  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  task automatic wait_req(input logic v);
    for (int i = 0; i < 600 && send_data !== v; i++)
      @(posedge clk);
  endtask : wait_req

  task automatic run_word(input logic c, input logic [15:0] d);
    word     <= d;
    sync_sel <= c;
    tx_en    <= 1'b1;
    wait_req(1'b1);
    tx_en    <= 1'b0;
    wait_req(1'b0);
    repeat (16) @(posedge clk);
    got = halves;
  endtask : run_word

  function automatic logic [79:0] exp_word(input logic c, input logic [15:0] d, input logic p);
    logic [1:0]  a;
    logic [79:0] e;
    a = c ? 2'b01 : 2'b10;
    e = {68'h0, a, a, a, ~a, ~a, ~a};
    for (int k = 0; k < 17; k++)
      e = {e[75:0], (((k < 16) ? d[15 - k] : p) ? 4'h6 : 4'h9)};
    return e;
  endfunction : exp_word

  // ----
  // Main sequence
  // ----
  initial
  begin
    {rst_n, mrst, tx_en, sync_sel, hsel, hwrite} = '0;
    inhibit_n = 1'b1;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = '0;
    hwdata = '0;
    word = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK("line_idle", 2'b11, ({line_pos_n, line_neg_n}));
    ahb(1'b0, OFF_CTRL, 32'h0);
    `CHK("ctrl_rst", ({31'h0, CTRL_DRIVE_RV}), rd);
    ahb(1'b0, OFF_WORDS, 32'h0);
    `CHK("words_rst", 32'h0, rd);
    ahb(1'b0, 8'h0C, 32'h0);
    `CHK("unmapped", 32'h0, rd);
    foreach (ROWS[i])
    begin
      row_t r;
      r = ROWS[i];
      run_word(r.cmd, r.data);
      exp_h = exp_word(r.cmd, r.data, r.par);
      `CHK("word", exp_h, got);
    end
    word     <= 16'h1234;
    tx_en    <= 1'b1;
    wait_req(1'b1);
    t0 = cyc;
    wait_req(1'b0);
    wait_req(1'b1);
    tx_en <= 1'b0;
    `CHK("word_span", 240, cyc - t0);
    wait_req(1'b0);
    repeat (60) @(posedge clk);
    `CHK("no_third", 1'b0, send_data);
    for (int m = 0; m < 2; m++)
    begin
      if (m == 0)
        inhibit_n <= 1'b0;
      else
        ahb(1'b1, OFF_CTRL, 32'h0);
      run_word(1'b1, 16'hC0DE);
      `CHK("line_held", {80{1'b1}}, got);
      inhibit_n <= 1'b1;
      ahb(1'b1, OFF_CTRL, 32'h1);
    end
    tx_en <= 1'b1;
    wait_req(1'b1);
    tx_en <= 1'b0;
    repeat (40) @(posedge clk);
    mrst <= 1'b1;
    repeat (3) @(posedge clk);
    mrst <= 1'b0;
    repeat (20) @(posedge clk);
    `CHK("abort_req", 1'b0, send_data);
    `CHK("abort_line", 2'b11, ({line_pos_n, line_neg_n}));
    // Register abort in mid-word, status seen while requesting
    sync_sel <= 1'b1;
    tx_en    <= 1'b1;
    wait_req(1'b1);
    tx_en    <= 1'b0;
    ahb(1'b0, OFF_STATUS, 32'h0);
    `CHK("status_busy", 32'h00000007, rd);
    ahb(1'b1, OFF_CTRL, 32'h00000003);
    repeat (20) @(posedge clk);
    `CHK("reg_abort_req", 1'b0, send_data);
    `CHK("reg_abort_line", 2'b11, ({line_pos_n, line_neg_n}));
    ahb(1'b0, OFF_CTRL, 32'h0);
    `CHK("abort_reads_0", 32'h00000001, rd);
    run_word(1'b0, 16'h8421);
    `CHK("after_abort", exp_word(1'b0, 16'h8421, 1'b1), got);
    repeat (20) @(posedge clk);
    ahb(1'b0, OFF_WORDS, 32'h0);
    `CHK("words", 32'h00000009, rd);
    ahb(1'b0, OFF_STATUS, 32'h0);
    `CHK("status_idle", 32'h0, rd);
    give_verdict();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule : manchester_word_encoder_bench
